// File: logic/irq_prio_map.vh
// Register map, field positions, reset values and vectors of the interrupt prioritizer
`ifndef IRQ_PRIO_MAP_VH
`define IRQ_PRIO_MAP_VH

// ****************************************
// Register byte addresses
// ****************************************
`define MISC_CTRL_OFS 8'h0c
`define STATUS_OFS 8'h10
`define CAN_EN_OFS 8'h20

// ****************************************
// Miscellaneous control fields
// ****************************************
`define MISC_SENSE_P_BIT 7
`define MISC_SENSE_N_BIT 6
`define MISC_EXT_EN_BIT 3
`define MISC_WO_EN_BIT 0
`define EXT_EN_RESET 1'b0
`define SENSE_P_RESET 1'b0
`define SENSE_N_RESET 1'b0
`define WO_EN_RESET 1'b0
`define CAN_EN_RESET 4'h0

// ****************************************
// Sensitivity codes, {sense_p, sense_n}
// ****************************************
`define SENSE_FALL 2'h0
`define SENSE_LOW 2'h1
`define SENSE_RISE 2'h2
`define SENSE_FALL2 2'h3

// ****************************************
// Source numbers, highest priority first
// ****************************************
`define SRC_RESET 3'h0
`define SRC_TRAP 3'h1
`define SRC_EXT 3'h2
`define SRC_CAP 3'h3
`define SRC_CMP 3'h4
`define SRC_OVF 3'h5
`define SRC_SCI 3'h6
`define SRC_CAN 3'h7

// ****************************************
// Vector pair addresses, first byte
// ****************************************
`define VEC_RESET 16'h3ffe
`define VEC_TRAP 16'h3ffc
`define VEC_EXT 16'h3ffa
`define VEC_CAP 16'h3ff8
`define VEC_CMP 16'h3ff6
`define VEC_OVF 16'h3ff4
`define VEC_SCI 16'h3ff2
`define VEC_CAN 16'h3ff0

// ****************************************
// Sequencer states
// ****************************************
`define ST_IDLE 1'b0
`define ST_REQ 1'b1

`endif

// File: logic/mcu_interrupt_prioritizer.v
// Interrupt prioritizer and external interrupt front end with Avalon-MM registers
// What this block does
// R1 - Of several pending requests, the highest fixed priority one goes first.
// R2 - Order: reset, trap, external/wired-OR, capture, compare, overflow, serial, CAN.
// R3 - Each source has its own fixed two-byte vector pair address.
// R4 - The software trap is taken whatever the mask flag; vector pair 3ffc.
// R5 - Trap waits for requests pending at its fetch, beats newer ones.
// R6 - Mask flag set holds off all maskable requests; clearing releases them.
// R7 - Edge latch clears at service start, so one new pulse can latch.
// R8 - An edge seen while external enable is off stays latched until enabled.
// R9 - Low-level requests are never latched; one edge pulse held at most.
// R10 - Pin request needs mask clear, enable set and the chosen sensitivity.
// R11 - Enable and both sensitivity bits live in control register 0x0c.
// R12 - Taking a request sets the mask, blocking others until serviced.
// R13 - Pin and wired-OR requests share vector pair 3ffa.
// R14 - Wired-OR uses input port B pins and its pin, needs enable and option.
// R15 - An enabled wired-OR input pulled high raises an external request.
// R16 - Any reset clears the wired-OR enable bit.
// R17 - A wired-OR request wakes the part from stop.
// R18 - External enable gates both; pin and wired-OR are OR-ed before sensing.
// R19 - Each CAN source has its own enable, except wake-up which is always on.
// R20 - Sensitivity bits select falling edge, rising edge or low level.
// R21 - Peripheral requests stay while flagged; priority is redone each boundary.
`include "irq_prio_map.vh"

module mcu_interrupt_prioritizer #(
   parameter [0:0] WIRED_OR_BUILT = 1'b1
) (
   input wire mclk,
   input wire reset_n,
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output wire [31:0] avs_readdata,
   output wire avs_waitrequest,
   input wire irq_n,
   input wire [7:0] port_b_in,
   input wire [7:0] port_b_is_input,
   input wire wired_or_input_pin,
   input wire ccr_mask,
   input wire instr_boundary,
   input wire trap_fetch,
   input wire service_ack,
   input wire capture_flag_one,
   input wire capture_flag_two,
   input wire compare_flag_one,
   input wire compare_flag_two,
   input wire timer_wrap_flag,
   input wire capture_en,
   input wire compare_en,
   input wire wrap_en,
   input wire serial_req,
   input wire [4:0] can_flags,
   output wire irq_request,
   output wire [15:0] vector_addr,
   output wire [2:0] source_id,
   output wire mask_set,
   output wire stop_wake
);

   // ****************************************
   // State
   // ****************************************
   reg wait_q;
   reg [31:0] rdata_q;
   reg ext_en_q;
   reg sense_p_q;
   reg sense_n_q;
   reg wo_en_q;
   reg [3:0] can_en_q;
   reg lvl_prev_q;
   reg ext_latch_q;
   reg reset_pend_q;
   reg trap_pend_q;
   reg [7:0] older_q;
   reg state_q;
   reg [2:0] src_q;
   reg [15:0] vec_q;
   reg mask_set_q;
   reg wake_q;
   reg [31:0] rd_d;
   reg [7:0] misc_rd;
   reg [2:0] win_d;
   reg win_ok_d;
   reg [15:0] vec_d;
   wire req_w;
   wire done_w;
   wire wr_w;
   wire wo_any_w;
   wire lvl_w;
   wire [1:0] sense_w;
   wire low_mode_w;
   wire edge_w;
   wire ext_raw_w;
   wire can_req_w;
   wire [7:0] mreq_w;
   wire [7:0] m_ok_w;
   wire [7:0] pend_w;
   wire [7:0] old_live_w;
   wire take_w;
   wire ack_w;
   // ****************************************
   // Avalon-MM slave
   // ****************************************
   // Every access answers exactly one cycle after it is raised
   assign req_w = avs_read | avs_write;
   assign done_w = req_w & ~wait_q;
   assign wr_w = done_w & avs_write & avs_byteenable[0];
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wait_q <= 1'b1;
      end else begin
         wait_q <= ~(req_w & wait_q);
      end
   end

   // Read data captured while the request waits, stands at the answer edge
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= 32'h00000000;
      end else if (avs_read & wait_q) begin
         rdata_q <= rd_d;
      end
   end

   // Control bit assembly, unused bits read zero
   always @* begin
      misc_rd = 8'h00;
      misc_rd[`MISC_SENSE_P_BIT] = sense_p_q; // R11
      misc_rd[`MISC_SENSE_N_BIT] = sense_n_q; // R11
      misc_rd[`MISC_EXT_EN_BIT] = ext_en_q; // R11
      misc_rd[`MISC_WO_EN_BIT] = wo_en_q;
   end

   // Read decode, unmapped addresses answer zero
   always @* begin
      rd_d = 32'h00000000;
      case (avs_address)
         `MISC_CTRL_OFS: begin
            rd_d = {24'h000000, misc_rd};
         end
         `STATUS_OFS: begin
            rd_d = {8'h00, vec_q, pend_w[7:0]};
            rd_d[31] = state_q;
            rd_d[30:28] = src_q;
            rd_d[27] = ext_latch_q;
         end
         `CAN_EN_OFS: begin
            rd_d = {28'h0000000, can_en_q};
         end
         default: begin
            rd_d = 32'h00000000;
         end
      endcase
   end

   // Register writes, only lane 0 carries bits
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ext_en_q <= `EXT_EN_RESET;
         sense_p_q <= `SENSE_P_RESET;
         sense_n_q <= `SENSE_N_RESET;
         wo_en_q <= `WO_EN_RESET; // R16
         can_en_q <= `CAN_EN_RESET;
      end else if (wr_w) begin
         if (avs_address == `MISC_CTRL_OFS) begin
            ext_en_q <= avs_writedata[`MISC_EXT_EN_BIT]; // R11
            sense_p_q <= avs_writedata[`MISC_SENSE_P_BIT];
            sense_n_q <= avs_writedata[`MISC_SENSE_N_BIT];
            wo_en_q <= avs_writedata[`MISC_WO_EN_BIT];
         end
         if (avs_address == `CAN_EN_OFS) begin
            can_en_q <= avs_writedata[3:0];
         end
      end
   end

   assign avs_waitrequest = wait_q;
   assign avs_readdata = rdata_q;
   // ****************************************
   // External and wired-OR front end
   // ****************************************
   // Wired-OR only on pins set as inputs, and only when built in
   assign wo_any_w = WIRED_OR_BUILT & wo_en_q & // R14
      (wired_or_input_pin | (|(port_b_in & port_b_is_input))); // R15

   // Combined request level, high means requesting
   assign lvl_w = ~irq_n | wo_any_w; // R18
   assign sense_w = {sense_p_q, sense_n_q};
   assign low_mode_w = (sense_w == `SENSE_LOW); // R20
   // Edge choice; the spare code falls back to the asserting edge
   assign edge_w = (sense_w == `SENSE_RISE) ? (lvl_prev_q & ~lvl_w) :
      (lvl_w & ~lvl_prev_q); // R20

   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         lvl_prev_q <= 1'b0;
      end else begin
         lvl_prev_q <= lvl_w;
      end
   end

   // Single latch, so at most one pulse waits; a new edge beats the clear
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ext_latch_q <= 1'b0;
      end else if (edge_w & ~low_mode_w) begin
         ext_latch_q <= 1'b1; // R8 R9
      end else if (ack_w & (src_q == `SRC_EXT)) begin
         ext_latch_q <= 1'b0; // R7
      end
   end

   // Latched edge or live low level, both behind the enable
   assign ext_raw_w = ext_en_q & // R10 R18
      (ext_latch_q | (low_mode_w & lvl_w)); // R9

   // Stop wake follows the wired-OR request
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= wo_any_w; // R17
      end
   end

   // ****************************************
   // Request vector
   // ****************************************
   // Wake-up bypasses the enables
   assign can_req_w = can_flags[4] | (|(can_flags[3:0] & can_en_q)); // R19
   // Peripheral requests are levels from their flags
   assign mreq_w[`SRC_RESET] = 1'b0;
   assign mreq_w[`SRC_TRAP] = 1'b0;
   assign mreq_w[`SRC_EXT] = ext_raw_w; // R13
   assign mreq_w[`SRC_CAP] = capture_en & (capture_flag_one | capture_flag_two); // R21
   assign mreq_w[`SRC_CMP] = compare_en & (compare_flag_one | compare_flag_two);
   assign mreq_w[`SRC_OVF] = wrap_en & timer_wrap_flag;
   assign mreq_w[`SRC_SCI] = serial_req;
   assign mreq_w[`SRC_CAN] = can_req_w;
   // Mask flag holds off everything maskable
   assign m_ok_w = mreq_w & {8{~ccr_mask}}; // R6 R10
   // Trap and reset ignore the mask
   assign pend_w = m_ok_w | {6'h00, trap_pend_q, reset_pend_q}; // R4
   // Requests that were already waiting when the trap was fetched
   assign old_live_w = older_q & m_ok_w; // R5

   // ****************************************
   // Priority choice
   // ****************************************
   // Lowest index wins; loop runs high to low so the last hit stands
   function [2:0] first_set;
      input [7:0] v;
      integer i;
      begin
         first_set = 3'h0;
         for (i = 7; i >= 0; i = i - 1) begin
            if (v[i]) begin
               first_set = i[2:0];
            end
         end
      end
   endfunction

   // Reset first, then older requests ahead of a waiting trap
   always @* begin
      win_ok_d = |pend_w;
      if (reset_pend_q) begin
         win_d = `SRC_RESET;
      end else if (trap_pend_q & (|old_live_w)) begin
         win_d = first_set(old_live_w); // R5
      end else begin
         win_d = first_set(pend_w); // R1 R2
      end
   end

   // Fixed vector per source
   always @* begin
      case (win_d)
         `SRC_RESET: begin
            vec_d = `VEC_RESET; // R3
         end
         `SRC_TRAP: begin
            vec_d = `VEC_TRAP; // R4
         end
         `SRC_EXT: begin
            vec_d = `VEC_EXT; // R13
         end
         `SRC_CAP: begin
            vec_d = `VEC_CAP; // R3
         end
         `SRC_CMP: begin
            vec_d = `VEC_CMP;
         end
         `SRC_OVF: begin
            vec_d = `VEC_OVF;
         end
         `SRC_SCI: begin
            vec_d = `VEC_SCI;
         end
         default: begin
            vec_d = `VEC_CAN;
         end
      endcase
   end

   // ****************************************
   // Service sequencer
   // ****************************************
   // Choice is redone at every instruction boundary; reset needs none
   assign take_w = (state_q == `ST_IDLE) & win_ok_d &
      (instr_boundary | reset_pend_q); // R21
   assign ack_w = (state_q == `ST_REQ) & service_ack;
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= `ST_IDLE;
         src_q <= `SRC_RESET;
         vec_q <= `VEC_RESET;
      end else begin
         case (state_q)
            `ST_IDLE: begin
               if (take_w) begin
                  state_q <= `ST_REQ;
                  src_q <= win_d;
                  vec_q <= vec_d;
               end
            end
            `ST_REQ: begin
               if (service_ack) begin
                  state_q <= `ST_IDLE;
               end
            end
            default: begin
               state_q <= `ST_IDLE;
            end
         endcase
      end
   end

   // Mask set pulse one cycle after the stacking start, blocks further requests
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         mask_set_q <= 1'b0;
      end else begin
         mask_set_q <= ack_w; // R12
      end
   end

   // Reset vector owed from reset release until serviced
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         reset_pend_q <= 1'b1;
      end else if (ack_w & (src_q == `SRC_RESET)) begin
         reset_pend_q <= 1'b0;
      end
   end

   // Trap pending from its fetch; a fresh fetch beats the clear
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         trap_pend_q <= 1'b0;
      end else if (trap_fetch) begin
         trap_pend_q <= 1'b1; // R4
      end else if (ack_w & (src_q == `SRC_TRAP)) begin
         trap_pend_q <= 1'b0;
      end
   end

   // Snapshot of older requests, each bit dropped once it is served
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         older_q <= 8'h00;
      end else if (trap_fetch) begin
         older_q <= m_ok_w; // R5
      end else if (ack_w) begin
         if (src_q == `SRC_TRAP) begin
            older_q <= 8'h00;
         end else begin
            older_q <= older_q & ~(8'h01 << src_q);
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign irq_request = state_q;
   assign vector_addr = vec_q;
   assign source_id = src_q;
   assign mask_set = mask_set_q;
   assign stop_wake = wake_q;
endmodule

// File: tb/irq_prio_checker.sv
// Port-level assertions for the interrupt prioritizer
module irq_prio_checker (
   input wire mclk,
   input wire reset_n,
   input wire avs_read,
   input wire avs_write,
   input wire avs_waitrequest,
   input wire irq_request,
   input wire [15:0] vector_addr,
   input wire [2:0] source_id,
   input wire mask_set,
   input wire service_ack,
   input wire ccr_mask,
   input wire instr_boundary,
   input wire stop_wake,
   input wire wired_or_input_pin,
   input wire [7:0] port_b_in,
   input wire [7:0] port_b_is_input
);
   timeunit 1ns;
   timeprecision 100ps;
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   // Vector follows source, two bytes apart, lowest source number at the top
   a_vec_map:
      assert property (irq_request |-> vector_addr == 16'h3ffe - {12'h000, source_id, 1'b0})
      else $error("vector does not match source");
   // Request held steady until the core starts stacking
   a_req_holds:
      assert property (irq_request && !service_ack |=> irq_request && $stable(vector_addr)
         && $stable(source_id))
      else $error("request changed before ack");
   a_ack_clears:
      assert property (irq_request && service_ack |=> !irq_request && mask_set)
      else $error("ack did not end request and set mask");
   a_mask_single:
      assert property (mask_set |-> $past(irq_request & service_ack) ##1 !mask_set)
      else $error("mask pulse without ack or too long");
   // With the I-bit set only reset or trap may start
   a_masked_only:
      assert property ($rose(irq_request) && $past(ccr_mask) |-> source_id <= 3'h1)
      else $error("maskable taken while masked");
   a_take_boundary:
      assert property ($rose(irq_request) && source_id != 3'h0 |-> $past(instr_boundary))
      else $error("request taken off a boundary");
   a_wake_cause:
      assert property ($rose(stop_wake) |->
         $past(wired_or_input_pin | (|(port_b_in & port_b_is_input))))
      else $error("wake without wired-OR input");
   // Bus answers in the cycle after the request, for one cycle only
   a_bus_answer:
      assert property ((avs_read | avs_write) & avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   a_bus_wait:
      assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");

   // Main scenarios reached
   c_trap: cover property ($rose(irq_request) && source_id == 3'h1);
   c_mask: cover property (mask_set);
   c_wake: cover property ($rose(stop_wake));
endmodule

bind mcu_interrupt_prioritizer irq_prio_checker chk (
   .mclk, .reset_n, .avs_read, .avs_write, .avs_waitrequest, .irq_request, .vector_addr,
   .source_id, .mask_set, .service_ack, .ccr_mask, .instr_boundary, .stop_wake,
   .wired_or_input_pin, .port_b_in, .port_b_is_input
);

// File: tb/core_seq_model.sv
// Behavioural model of the processor core fetch and stacking sequencer
module core_seq_model (
   input wire mclk,
   input wire reset_n,
   input wire irq_request,
   input wire mask_set,
   input wire unmask,
   input wire slow,
   output reg instr_boundary,
   output reg service_ack,
   output reg ccr_mask
);
   timeunit 1ns;
   timeprecision 100ps;
   reg [1:0] beat_q;
   reg [2:0] wait_q;
   // ****************************************
   // Core sequencing
   // ****************************************
   // No boundary while stacking, as the real core is busy pushing state
   always @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         beat_q <= 2'h0;
         wait_q <= 3'h0;
         instr_boundary <= 1'b0;
         service_ack <= 1'b0;
         ccr_mask <= 1'b1;
      end else begin
         beat_q <= beat_q + 2'h1;
         instr_boundary <= beat_q == 2'h2 && !irq_request && !service_ack && !mask_set;
         wait_q <= (irq_request && !service_ack) ? wait_q + 3'h1 : 3'h0;
         service_ack <= irq_request && !service_ack && wait_q >= (slow ? 3'h4 : 3'h0);
         // I-bit set on stacking, cleared only when the bench opens it
         if (service_ack || mask_set)
            ccr_mask <= 1'b1;
         else if (unmask)
            ccr_mask <= 1'b0;
      end
   end
endmodule

// File: tb/mcu_interrupt_prioritizer_tb_top.sv
// Self-checking bench for the interrupt prioritizer
module mcu_interrupt_prioritizer_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   reg mclk, reset_n, avs_read, avs_write, irq_n, wired_or_input_pin, trap_fetch;
   reg serial_req, unmask, slow;
   reg [7:0] avs_address, port_b_in, port_b_is_input;
   reg [31:0] avs_writedata, rd;
   reg [3:0] avs_byteenable;
   reg [4:0] can_flags;
   reg [2:0] tmr;
   wire [31:0] avs_readdata;
   wire [15:0] vector_addr;
   wire [2:0] source_id;
   wire avs_waitrequest, irq_request, mask_set, stop_wake, instr_boundary, service_ack, ccr_mask;
   integer n_errors, checked, cycles;

   mcu_interrupt_prioritizer dut (
      .mclk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
      .avs_readdata, .avs_waitrequest, .irq_n, .port_b_in, .port_b_is_input,
      .wired_or_input_pin, .ccr_mask, .instr_boundary, .trap_fetch, .service_ack,
      .capture_flag_one(tmr[2]), .capture_flag_two(1'b0), .compare_flag_one(1'b0),
      .compare_flag_two(tmr[1]), .timer_wrap_flag(tmr[0]), .capture_en(1'b1),
      .compare_en(1'b1), .wrap_en(1'b1), .serial_req, .can_flags, .irq_request,
      .vector_addr, .source_id, .mask_set, .stop_wake
   );
   core_seq_model core (
      .mclk, .reset_n, .irq_request, .mask_set, .unmask, .slow, .instr_boundary,
      .service_ack, .ccr_mask
   );

   // ****************************************
   // Clock, watchdog and shared tasks
   // ****************************************
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // Cut a hung run short
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         n_errors = n_errors + 1;
         wrap_up;
      end
   end
   task wrap_up;
      begin
         $display("comparisons %0d mismatches %0d", checked, n_errors);
         if (n_errors == 0 && checked > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task cmp(input [31:0] got, input [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Request held until waitrequest is sampled low at a rising edge
   task bus(input w, input [7:0] a, input [31:0] d, input [3:0] be);
      integer n;
      begin
         @(posedge mclk);
         avs_read <= !w;
         avs_write <= w;
         {avs_address, avs_writedata, avs_byteenable} <= {a, d, be};
         n = 0;
         @(posedge mclk);
         while (avs_waitrequest !== 1'b0 && n < 50) begin
            @(posedge mclk);
            n = n + 1;
         end
         rd = avs_readdata;
         avs_read <= 1'b0;
         avs_write <= 1'b0;
      end
   endtask
   task expect_irq(input [2:0] src);
      integer n;
      begin
         n = 0;
         @(negedge mclk);
         while (irq_request !== 1'b1 && n < 80) begin
            @(negedge mclk);
            n = n + 1;
         end
         cmp({31'h0, irq_request}, 32'h1);
         cmp({29'h0, source_id}, {29'h0, src});
         cmp({16'h0, vector_addr}, 32'h3ffe - {28'h0, src, 1'b0});
         while (irq_request !== 1'b0 && n < 160) begin
            @(negedge mclk);
            n = n + 1;
         end
         cmp({31'h0, mask_set}, 32'h1);
         @(posedge mclk);
      end
   endtask
   task no_irq(input integer k);
      reg seen;
      begin
         seen = 1'b0;
         repeat (k) begin
            @(negedge mclk);
            if (irq_request !== 1'b0)
               seen = 1'b1;
         end
         cmp({31'h0, seen}, 32'h0);
      end
   endtask
   task open_mask;
      begin
         @(posedge mclk);
         unmask <= 1'b1;
         @(posedge mclk);
         unmask <= 1'b0;
      end
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task t_reset;
      begin
         @(posedge mclk);
         reset_n <= 1'b0;
         repeat (2) @(posedge mclk);
         reset_n <= 1'b1;
         expect_irq(3'h0);
         bus(1'b0, 8'h0c, 32'h0, 4'h1);
         cmp(rd & 32'hff, 32'h0);
         $display("reset test done");
      end
   endtask
   task t_regs;
      begin
         bus(1'b1, 8'h0c, 32'hc9, 4'h1);
         bus(1'b0, 8'h0c, 32'h0, 4'h1);
         cmp(rd & 32'hff, 32'hc9);
         bus(1'b1, 8'h0c, 32'h0, 4'h0);
         bus(1'b0, 8'h0c, 32'h0, 4'h1);
         cmp(rd & 32'hff, 32'hc9);
         bus(1'b1, 8'h04, 32'hff, 4'h1);
         bus(1'b0, 8'h04, 32'h0, 4'h1);
         cmp(rd, 32'h0);
         bus(1'b1, 8'h0c, 32'h0, 4'h1);
         $display("register test done");
      end
   endtask
   // All peripherals at once, each cleared in turn after it is served
   task t_prio;
      integer i;
      begin
         @(posedge mclk);
         {tmr, serial_req, can_flags} <= {3'h7, 1'b1, 5'h10};
         no_irq(20);
         for (i = 3; i < 8; i = i + 1) begin
            open_mask;
            expect_irq(i[2:0]);
            tmr <= tmr >> 1;
            serial_req <= i < 6;
            can_flags <= (i < 7) ? 5'h10 : 5'h00;
         end
         $display("priority test done");
      end
   endtask
   task t_trap;
      begin
         @(posedge mclk);
         tmr <= 3'h4;
         trap_fetch <= 1'b1;
         @(posedge mclk);
         trap_fetch <= 1'b0;
         expect_irq(3'h1);
         tmr <= 3'h0;
         // Serial pending before the fetch must still go first
         serial_req <= 1'b1;
         open_mask;
         trap_fetch <= 1'b1;
         @(posedge mclk);
         trap_fetch <= 1'b0;
         expect_irq(3'h6);
         expect_irq(3'h1);
         serial_req <= 1'b0;
         $display("trap test done");
      end
   endtask
   task t_ext(input [7:0] mode);
      begin
         bus(1'b1, 8'h0c, {24'h0, mode}, 4'h1);
         @(posedge mclk);
         irq_n <= 1'b0;
         bus(1'b0, 8'h10, 32'h0, 4'h1);
         cmp({31'h0, rd[27]}, {31'h0, mode != 8'h80});
         @(posedge mclk);
         irq_n <= 1'b1;
         open_mask;
         no_irq(12);
         bus(1'b0, 8'h10, 32'h0, 4'h1);
         cmp({31'h0, rd[27]}, 32'h1);
         bus(1'b1, 8'h0c, {24'h0, mode | 8'h08}, 4'h1);
         expect_irq(3'h2);
         bus(1'b0, 8'h10, 32'h0, 4'h1);
         cmp({31'h0, rd[27]}, 32'h0);
         $display("edge test done");
      end
   endtask
   task t_low;
      begin
         bus(1'b1, 8'h0c, 32'h48, 4'h1);
         @(posedge mclk);
         irq_n <= 1'b0;
         repeat (3) @(posedge mclk);
         irq_n <= 1'b1;
         open_mask;
         no_irq(12);
         bus(1'b0, 8'h10, 32'h0, 4'h1);
         cmp({31'h0, rd[27]}, 32'h0);
         irq_n <= 1'b0;
         expect_irq(3'h2);
         irq_n <= 1'b1;
         $display("level test done");
      end
   endtask
   task t_wo;
      begin
         bus(1'b1, 8'h0c, 32'h09, 4'h1);
         {port_b_is_input, port_b_in} <= 16'h0102;
         repeat (3) @(negedge mclk);
         cmp({31'h0, stop_wake}, 32'h0);
         @(posedge mclk);
         port_b_in <= 8'h03;
         repeat (3) @(negedge mclk);
         cmp({31'h0, stop_wake}, 32'h1);
         open_mask;
         expect_irq(3'h2);
         port_b_in <= 8'h00;
         @(posedge mclk);
         wired_or_input_pin <= 1'b1;
         open_mask;
         expect_irq(3'h2);
         wired_or_input_pin <= 1'b0;
         $display("wired-OR test done");
      end
   endtask
   task t_can;
      begin
         {slow, can_flags} <= {1'b1, 5'h01};
         open_mask;
         no_irq(12);
         bus(1'b1, 8'h20, 32'h01, 4'h1);
         expect_irq(3'h7);
         can_flags <= 5'h00;
         $display("CAN test done");
      end
   endtask

   initial begin
      reset_n = 1'b0;
      {avs_read, avs_write, trap_fetch, serial_req, unmask, slow, wired_or_input_pin} = 7'h0;
      irq_n = 1'b1;
      {avs_address, port_b_in, port_b_is_input, avs_byteenable} = 28'h0;
      {avs_writedata, rd, can_flags, tmr} = 72'h0;
      n_errors = 0;
      checked = 0;
      cycles = 0;
      t_reset;
      t_regs;
      t_prio;
      t_trap;
      t_ext(8'h00);
      t_ext(8'h80);
      t_ext(8'hc0);
      t_low;
      t_wo;
      t_reset;
      t_can;
      wrap_up;
   end
endmodule
